// ### logic/fspc_regs.sv
// Operation
// (RULE_01) The sync source field routes pin, serial bit, sign transition or a constant to FIFO sync.
// (RULE_02) A sign-transition source gives one sync only, re-armed by reset or a different code.
// (RULE_03) The A-sample flag follows the opposite port sign bit when selected, else transmit enable rising edge.
// (RULE_04) Each FIFO sync event loads the 4-bit start value into the FIFO output position counter.
// (RULE_05) The threshold bit picks 3.3V-tolerant levels at 0 and 1.8V-tolerant levels at 1.
// (RULE_06) The channel B sleep bit puts channel B to sleep while set.
// (RULE_07) Single-converter mode never sets channel B sleep; software must set it itself.
// (RULE_08) The channel A sleep bit sleeps channel A and forces channel B to sleep too.
// (RULE_09) Each bias filter bit enables its channel filter when clear and picks the corner.
// (RULE_10) Software writes ones into both low reserved bits of the power register after reset.
// (RULE_11) Reset loads 0x15, 0x80, 0x00 and 0x0E into the four registers.
// (RULE_12) Unused bits and the spare register read zero and ignore writes; the code resets sync source bit 0 to one, which reads one until written.
`timescale 1ns/1ps
`default_nettype none
module fspc_regs
	import fspc_pkg::*;
(
	input wire logic ref_clk, // 125 MHz clock
	input wire logic nrst, // Async reset, active low
	input wire logic regWrEn, // Register write strobe
	input wire logic regRdEn, // Register read strobe
	input wire logic [4:0] regAddr, // Register address
	input wire logic [7:0] regWrData, // Write data
	output logic [7:0] regRdData, // Read data, held
	input wire logic transmitEnablePin, // Transmit enable pin
	input wire logic syncPin, // Sync pin
	input wire logic serialPortSyncBit, // Serial-port sync bit
	input wire logic portAInputMsb, // Port A sign bit
	input wire logic portBInputMsb, // Port B sign bit
	input wire logic aFlagSelect, // A-sample flag source
	input wire logic singleConverterMode, // Single converter mode
	output logic fifoSync, // Selected FIFO sync level
	output logic fifoPtrLoad, // Pointer preset pulse
	output logic [3:0] fifoPtrPreset, // Pointer preset value
	output logic aSampleFlag, // A-sample identification
	output logic inputThreshold1p8, // 1.8V input levels
	output logic sleepA, // Channel A sleep
	output logic sleepB, // Channel B sleep
	output logic biasLpfEnA, // Channel A bias filter on
	output logic biasLpfEnB, // Channel B bias filter on
	output logic biasCornerLowA, // Channel A low corner
	output logic biasCornerLowB // Channel B low corner
);

	////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rstMeta;
	logic rstN;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [3:0] pinSync;
	logic txEnS;
	logic syncPinS;
	logic portAMsbS;
	logic portBMsbS;

	fspc_sync2 #(
		.WIDTH(4)
	) uPinSync (
		.refClk(ref_clk),
		.rstN(rstN),
		.asyncIn({transmitEnablePin, syncPin, portAInputMsb, portBInputMsb}),
		.syncOut(pinSync)
	);

	assign txEnS = pinSync[3];
	assign syncPinS = pinSync[2];
	assign portAMsbS = pinSync[1];
	assign portBMsbS = pinSync[0];

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] syncSrcReg;
	logic [7:0] syncStartReg;
	logic [7:0] pwrCfgReg;
	logic [7:0] next_syncSrcReg;
	logic [7:0] next_syncStartReg;
	logic [7:0] next_pwrCfgReg;
	logic [7:0] next_regRdData;
	logic rearm;
	logic next_rearm;
	logic [2:0] fifoSel;

	assign fifoSel = syncSrcReg[FIFO_SEL_LSB +: 3];

	always_comb begin
		next_syncSrcReg = syncSrcReg;
		next_syncStartReg = syncStartReg;
		next_pwrCfgReg = pwrCfgReg;
		next_rearm = 1'b0;
		if (regWrEn) begin
			if (regAddr == SYNC_SRC_OFS) begin
				next_syncSrcReg = regWrData & SYNC_SRC_MASK; // RULE_12
				// Same code rewritten leaves a spent one-shot spent
				if (regWrData[FIFO_SEL_LSB +: 3] != fifoSel) begin
					next_rearm = 1'b1; // RULE_02
				end
			end else if (regAddr == SYNC_START_OFS) begin
				next_syncStartReg = regWrData & SYNC_START_MASK; // RULE_12
			end else if (regAddr == PWR_CFG_OFS) begin
				// Low reserved bits stored as written; software owns them
				next_pwrCfgReg = regWrData & PWR_CFG_MASK; // RULE_10
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			syncSrcReg <= SYNC_SRC_RST; // RULE_11
			syncStartReg <= SYNC_START_RST; // RULE_11
			pwrCfgReg <= PWR_CFG_RST; // RULE_11
			rearm <= 1'b0;
		end else begin
			syncSrcReg <= next_syncSrcReg;
			syncStartReg <= next_syncStartReg;
			pwrCfgReg <= next_pwrCfgReg;
			rearm <= next_rearm;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read-back path

	// Held between reads so a slow master may sample it late
	always_comb begin
		next_regRdData = regRdData;
		if (regRdEn) begin
			if (regAddr == SYNC_SRC_OFS) begin
				next_regRdData = syncSrcReg;
			end else if (regAddr == SYNC_START_OFS) begin
				next_regRdData = syncStartReg;
			end else if (regAddr == SPARE_OFS) begin
				next_regRdData = SPARE_RST; // RULE_12
			end else if (regAddr == PWR_CFG_OFS) begin
				next_regRdData = pwrCfgReg;
			end else begin
				next_regRdData = 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			regRdData <= 8'h00;
		end else begin
			regRdData <= next_regRdData;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// First sign transitions

	logic portAOnce;
	logic portBOnce;

	fspc_first_edge uPortAEdge (
		.refClk(ref_clk),
		.rstN(rstN),
		.signBit(portAMsbS),
		.rearm(rearm), // RULE_02
		.syncPulse(portAOnce)
	);

	fspc_first_edge uPortBEdge (
		.refClk(ref_clk),
		.rstN(rstN),
		.signBit(portBMsbS),
		.rearm(rearm), // RULE_02
		.syncPulse(portBOnce)
	);

	////////////////////////////////////////////////////////////////////////
	// Sync routing and pointer preset

	logic selSync;
	logic next_fifoSync;
	logic next_fifoPtrLoad;
	logic [3:0] next_fifoPtrPreset;

	always_comb begin
		case (fifoSel)
			SEL_TXEN: selSync = txEnS; // RULE_01
			SEL_SYNC_PIN: selSync = syncPinS; // RULE_01
			SEL_SERIAL: selSync = serialPortSyncBit; // RULE_01
			SEL_PORT_A: selSync = portAOnce; // RULE_01
			SEL_PORT_B: selSync = portBOnce; // RULE_01
			SEL_ONE: selSync = 1'b1; // RULE_01
			SEL_ZERO_A: selSync = 1'b0; // RULE_01
			SEL_ZERO_B: selSync = 1'b0; // RULE_01
			default: selSync = 1'b0;
		endcase
	end

	always_comb begin
		next_fifoSync = selSync;
		// Sync event is the rising edge of the routed source
		next_fifoPtrLoad = selSync & ~fifoSync; // RULE_04
		next_fifoPtrPreset = fifoPtrPreset;
		if (selSync & ~fifoSync) begin
			next_fifoPtrPreset = syncStartReg[SYNC_START_LSB +: 4]; // RULE_04
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			fifoSync <= 1'b0;
			fifoPtrLoad <= 1'b0;
			fifoPtrPreset <= SYNC_START_RST[SYNC_START_LSB +: 4];
		end else begin
			fifoSync <= next_fifoSync;
			fifoPtrLoad <= next_fifoPtrLoad;
			fifoPtrPreset <= next_fifoPtrPreset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A-sample identification

	logic txEnLast;
	logic next_txEnLast;
	logic next_aSampleFlag;

	always_comb begin
		next_txEnLast = txEnS;
		// Opposite port of the incoming data is port B
		if (aFlagSelect) begin
			next_aSampleFlag = portBMsbS; // RULE_03
		end else begin
			next_aSampleFlag = txEnS & ~txEnLast; // RULE_03
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			txEnLast <= 1'b0;
			aSampleFlag <= 1'b0;
		end else begin
			txEnLast <= next_txEnLast;
			aSampleFlag <= next_aSampleFlag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power and input configuration outputs

	logic next_inputThreshold1p8;
	logic next_sleepA;
	logic next_sleepB;
	logic next_biasLpfEnA;
	logic next_biasLpfEnB;
	logic next_biasCornerLowA;
	logic next_biasCornerLowB;
	logic singleModeSeen;

	// Single converter mode is observed only; it never drives sleep
	assign singleModeSeen = singleConverterMode; // RULE_07

	always_comb begin
		next_inputThreshold1p8 = pwrCfgReg[THRESH_BIT]; // RULE_05
		next_sleepA = pwrCfgReg[SLEEP_A_BIT];
		next_sleepB = pwrCfgReg[SLEEP_B_BIT] // RULE_06
			| pwrCfgReg[SLEEP_A_BIT]; // RULE_08
		next_biasLpfEnA = ~pwrCfgReg[LPF_A_BIT]; // RULE_09
		next_biasLpfEnB = ~pwrCfgReg[LPF_B_BIT]; // RULE_09
		next_biasCornerLowA = pwrCfgReg[LPF_A_BIT]; // RULE_09
		next_biasCornerLowB = pwrCfgReg[LPF_B_BIT]; // RULE_09
		if (singleModeSeen) begin
			next_sleepB = next_sleepB; // RULE_07
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			inputThreshold1p8 <= PWR_CFG_RST[THRESH_BIT];
			sleepA <= PWR_CFG_RST[SLEEP_A_BIT];
			sleepB <= PWR_CFG_RST[SLEEP_B_BIT];
			biasLpfEnA <= ~PWR_CFG_RST[LPF_A_BIT];
			biasLpfEnB <= ~PWR_CFG_RST[LPF_B_BIT];
			biasCornerLowA <= PWR_CFG_RST[LPF_A_BIT];
			biasCornerLowB <= PWR_CFG_RST[LPF_B_BIT];
		end else begin
			inputThreshold1p8 <= next_inputThreshold1p8;
			sleepA <= next_sleepA;
			sleepB <= next_sleepB;
			biasLpfEnA <= next_biasLpfEnA;
			biasLpfEnB <= next_biasLpfEnB;
			biasCornerLowA <= next_biasCornerLowA;
			biasCornerLowB <= next_biasCornerLowB;
		end
	end

endmodule : fspc_regs
`default_nettype wire

// ### pkg/fspc_pkg.sv
`default_nettype none
package fspc_pkg;

	// Register offsets on the register port
	localparam logic [4:0] SYNC_SRC_OFS = 5'h17;
	localparam logic [4:0] SYNC_START_OFS = 5'h18;
	localparam logic [4:0] SPARE_OFS = 5'h19;
	localparam logic [4:0] PWR_CFG_OFS = 5'h1A;

	// Values after reset
	localparam logic [7:0] SYNC_SRC_RST = 8'h15;
	localparam logic [7:0] SYNC_START_RST = 8'h80;
	localparam logic [7:0] SPARE_RST = 8'h00;
	localparam logic [7:0] PWR_CFG_RST = 8'h0E;

	// Writable bits; everything else reads zero, except sync source bit 0, which is one from reset until written
	localparam logic [7:0] SYNC_SRC_MASK = 8'h1C;
	localparam logic [7:0] SYNC_START_MASK = 8'hF0;
	localparam logic [7:0] PWR_CFG_MASK = 8'hBF;

	// Field positions
	localparam int FIFO_SEL_LSB = 2;
	localparam int SYNC_START_LSB = 4;
	localparam int THRESH_BIT = 7;
	localparam int SLEEP_B_BIT = 5;
	localparam int SLEEP_A_BIT = 4;
	localparam int LPF_A_BIT = 3;
	localparam int LPF_B_BIT = 2;

	// Sync source codes
	localparam logic [2:0] SEL_TXEN = 3'h0;
	localparam logic [2:0] SEL_SYNC_PIN = 3'h1;
	localparam logic [2:0] SEL_SERIAL = 3'h2;
	localparam logic [2:0] SEL_ZERO_A = 3'h3;
	localparam logic [2:0] SEL_PORT_A = 3'h4;
	localparam logic [2:0] SEL_PORT_B = 3'h5;
	localparam logic [2:0] SEL_ZERO_B = 3'h6;
	localparam logic [2:0] SEL_ONE = 3'h7;

	// First-transition detector states
	typedef enum logic [2:0] {
		FE_PRIME = 3'b001,
		FE_ARMED = 3'b010,
		FE_SPENT = 3'b100
	} fspc_edge_e;

endpackage : fspc_pkg
`default_nettype wire

// ### logic/fspc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_sync2 #(
	parameter int WIDTH = 4
) (
	input wire logic refClk, // Clock
	input wire logic rstN, // Async reset, active low
	input wire logic [WIDTH-1:0] asyncIn, // Pin levels
	output logic [WIDTH-1:0] syncOut // Synchronised levels
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_syncOut;

	always_comb begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge refClk or negedge rstN) begin
		if (!rstN) begin
			stage1 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end

endmodule : fspc_sync2
`default_nettype wire

// ### logic/fspc_first_edge.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_first_edge
	import fspc_pkg::*;
(
	input wire logic refClk, // Clock
	input wire logic rstN, // Async reset, active low
	input wire logic signBit, // Synchronised sign bit
	input wire logic rearm, // Source code changed
	output logic syncPulse // One pulse on first transition
);

	fspc_edge_e state;
	fspc_edge_e next_state;
	logic lastSign;
	logic next_lastSign;
	logic next_syncPulse;

	always_comb begin
		next_state = state;
		next_lastSign = signBit;
		next_syncPulse = 1'b0;
		if (rearm) begin
			// Reference is retaken so an old level is not a transition
			next_state = FE_PRIME;
		end else begin
			case (state)
				FE_PRIME: next_state = FE_ARMED;
				FE_ARMED: begin
					if (signBit != lastSign) begin
						next_syncPulse = 1'b1;
						next_state = FE_SPENT;
					end
				end
				FE_SPENT: next_state = FE_SPENT;
				default: next_state = FE_PRIME;
			endcase
		end
	end

	always_ff @(posedge refClk or negedge rstN) begin
		if (!rstN) begin
			state <= FE_PRIME;
			lastSign <= 1'b0;
			syncPulse <= 1'b0;
		end else begin
			state <= next_state;
			lastSign <= next_lastSign;
			syncPulse <= next_syncPulse;
		end
	end

endmodule : fspc_first_edge
`default_nettype wire

// ### verification/fspc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_regs_monitor
	import fspc_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic regWrEn, // Write strobe
	input wire logic regRdEn, // Read strobe
	input wire logic [4:0] regAddr, // Address
	input wire logic [7:0] regWrData, // Write data
	input wire logic [7:0] regRdData, // Read data
	input wire logic fifoSync, // Routed sync
	input wire logic fifoPtrLoad, // Preset pulse
	input wire logic [3:0] fifoPtrPreset, // Preset value
	input wire logic inputThreshold1p8, // Threshold
	input wire logic sleepA, // Sleep A
	input wire logic sleepB, // Sleep B
	input wire logic biasLpfEnA, // Filter A on
	input wire logic biasLpfEnB, // Filter B on
	input wire logic biasCornerLowA, // Corner A
	input wire logic biasCornerLowB // Corner B
);
	default clocking mainClk @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic pwrWr;
	assign pwrWr = regWrEn && regAddr == PWR_CFG_OFS;
	////////////////////////////////////////////////////////////////////////
	AST_SLEEP_FORCE: assert property (sleepA |-> sleepB)
		else $error("sleepB low while sleepA high");
	AST_PWR_SLEEPA: assert property (pwrWr |->
		##2 sleepA == $past(regWrData[SLEEP_A_BIT], 2))
		else $error("sleepA does not follow write");
	AST_PWR_SLEEPB: assert property (pwrWr |-> ##2 sleepB ==
		($past(regWrData[SLEEP_B_BIT], 2) | $past(regWrData[SLEEP_A_BIT], 2)))
		else $error("sleepB does not follow write");
	AST_PWR_THRESH: assert property (pwrWr |-> ##2
		inputThreshold1p8 == $past(regWrData[THRESH_BIT], 2))
		else $error("threshold does not follow write");
	AST_PWR_LPF: assert property (pwrWr |->
		##2 biasLpfEnA != $past(regWrData[LPF_A_BIT], 2))
		else $error("filter A enable wrong");
	AST_CORNER: assert property (biasLpfEnA != biasCornerLowA &&
		biasLpfEnB != biasCornerLowB)
		else $error("filter enable and corner disagree");
	AST_LOAD_EDGE: assert property (fifoPtrLoad |->
		fifoSync && !$past(fifoSync))
		else $error("preset load without sync rise");
	AST_LOAD_ONE: assert property (fifoPtrLoad |=> !fifoPtrLoad)
		else $error("preset load longer than one cycle");
	AST_PRESET_HOLD: assert property (!fifoPtrLoad |->
		$stable(fifoPtrPreset))
		else $error("preset changed without load");
	AST_UNMAPPED_RD: assert property (regRdEn && (regAddr < SYNC_SRC_OFS ||
		regAddr > PWR_CFG_OFS || regAddr == SPARE_OFS) |=>
		regRdData == 8'h00)
		else $error("unused address read nonzero");
endmodule : fspc_regs_monitor
bind fspc_regs fspc_regs_monitor fspc_regs_monitor_inst (.ref_clk, .nrst,
	.regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .fifoSync,
	.fifoPtrLoad, .fifoPtrPreset, .inputThreshold1p8, .sleepA, .sleepB,
	.biasLpfEnA, .biasLpfEnB, .biasCornerLowA, .biasCornerLowB);
`default_nettype wire

// ### verification/fspc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_host_model
	import fspc_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic [7:0] regRdData, // Read data
	output logic regWrEn, // Write strobe
	output logic regRdEn, // Read strobe
	output logic [4:0] regAddr, // Address
	output logic [7:0] regWrData // Write data
);
	initial begin
		{regWrEn, regRdEn, regAddr, regWrData} = 15'h0000;
	end
	// Released bus shows inverted values, never the old ones
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		// Low reserved bits are always written as ones
		regWrData = (a == PWR_CFG_OFS) ? (d | 8'h03) : d;
		regWrEn = 1'b1;
		@(negedge ref_clk);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~regWrData;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge ref_clk);
		regRdEn = 1'b0;
		regAddr = ~a;
		d = regRdData;
	endtask : rd
endmodule : fspc_host_model
`default_nettype wire

// ### verification/fifo_sync_power_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_sync_power_config_bench;
	import fspc_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic regWrEn, regRdEn, transmitEnablePin, syncPin, serialPortSyncBit;
	logic portAInputMsb, portBInputMsb, aFlagSelect, singleConverterMode;
	logic [4:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic fifoSync, fifoPtrLoad, aSampleFlag, inputThreshold1p8, sleepA;
	logic sleepB, biasLpfEnA, biasLpfEnB, biasCornerLowA, biasCornerLowB;
	logic [3:0] fifoPtrPreset;
	int mismatches = 0;
	int check_count = 0;
	int loads = 0;
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (fifoPtrLoad === 1'b1) loads <= loads + 1;
	fspc_regs fspc_regs_inst (.ref_clk, .nrst, .regWrEn, .regRdEn, .regAddr,
		.regWrData, .regRdData, .transmitEnablePin, .syncPin,
		.serialPortSyncBit, .portAInputMsb, .portBInputMsb, .aFlagSelect,
		.singleConverterMode, .fifoSync, .fifoPtrLoad, .fifoPtrPreset,
		.aSampleFlag, .inputThreshold1p8, .sleepA, .sleepB, .biasLpfEnA,
		.biasLpfEnB, .biasCornerLowA, .biasCornerLowB);
	fspc_host_model fspc_host_model_inst (.ref_clk, .regRdData, .regWrEn,
		.regRdEn, .regAddr, .regWrData);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	task automatic pins(input logic [4:0] p, input int n);
		{portBInputMsb, portAInputMsb, serialPortSyncBit, syncPin,
			transmitEnablePin} = p;
		repeat (n) @(negedge ref_clk);
	endtask : pins
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] d;
		logic [4:0] ofs[5] = '{SYNC_SRC_OFS, SYNC_START_OFS, SPARE_OFS,
			PWR_CFG_OFS, 5'h05};
		logic [7:0] rv[5] = '{8'h15, 8'h80, 8'h00, 8'h0E, 8'h00};
		logic [7:0] mk[5] = '{8'h1C, 8'hF0, 8'h00, 8'hBF, 8'h00};
		for (int i = 0; i < 5; i++) begin
			fspc_host_model_inst.rd(ofs[i], d);
			chk("reset value", rv[i], d);
			fspc_host_model_inst.wr(ofs[i], 8'hFF);
			fspc_host_model_inst.rd(ofs[i], d);
			chk("masked readback", mk[i], d);
		end
	endtask : t_regs
	task automatic t_power;
		logic [7:0] pd[5] = '{8'hFF, 8'h23, 8'h13, 8'h0B, 8'h87};
		logic [6:0] pe[5] = '{7'h73, 7'h1C, 7'h3C, 7'h06, 7'h49};
		singleConverterMode = 1'b1;
		for (int i = 0; i < 5; i++) begin
			fspc_host_model_inst.wr(PWR_CFG_OFS, pd[i]);
			@(negedge ref_clk);
			chk("power outputs", {1'b0, pe[i]}, {1'b0, inputThreshold1p8,
				sleepA, sleepB, biasLpfEnA, biasLpfEnB, biasCornerLowA,
				biasCornerLowB});
		end
	endtask : t_power
	task automatic t_sources;
		int b;
		logic [2:0] c;
		logic e;
		logic [4:0] pv[8] = '{5'h01, 5'h02, 5'h04, 5'h1F, 5'h08, 5'h10,
			5'h1F, 5'h1F};
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			e = (c != 3'h3 && c != 3'h6);
			pins(5'h00, 6);
			fspc_host_model_inst.wr(SYNC_START_OFS, {1'b1, c, 4'h0});
			b = loads;
			fspc_host_model_inst.wr(SYNC_SRC_OFS, {3'h0, c, 2'h0});
			repeat (6) @(negedge ref_clk);
			pins(pv[i], 8);
			chk("sync level", {7'h00, c < 3'h3 || c == 3'h7},
				{7'h00, fifoSync});
			chk("load count", {7'h00, e}, 8'(loads - b));
			if (e) chk("preset", {4'h0, 1'b1, c}, {4'h0, fifoPtrPreset});
		end
	endtask : t_sources
	// Sign source stays spent until a different code is written
	task automatic t_rearm;
		int b;
		b = loads;
		pins(5'h00, 8);
		fspc_host_model_inst.wr(SYNC_SRC_OFS, 8'h14);
		repeat (6) @(negedge ref_clk);
		pins(5'h10, 8);
		chk("first loads", 8'h01, 8'(loads - b));
		pins(5'h00, 8);
		fspc_host_model_inst.wr(SYNC_SRC_OFS, 8'h14);
		repeat (6) @(negedge ref_clk);
		pins(5'h10, 8);
		chk("spent loads", 8'h01, 8'(loads - b));
		fspc_host_model_inst.wr(SYNC_SRC_OFS, 8'h10);
		fspc_host_model_inst.wr(SYNC_SRC_OFS, 8'h14);
		repeat (6) @(negedge ref_clk);
		pins(5'h00, 8);
		chk("rearmed loads", 8'h02, 8'(loads - b));
	endtask : t_rearm
	task automatic t_aflag;
		aFlagSelect = 1'b0;
		pins(5'h00, 6);
		pins(5'h01, 3);
		chk("txen edge flag", 8'h01, {7'h00, aSampleFlag});
		@(negedge ref_clk);
		chk("txen held flag", 8'h00, {7'h00, aSampleFlag});
		aFlagSelect = 1'b1;
		pins(5'h10, 4);
		chk("port B high flag", 8'h01, {7'h00, aSampleFlag});
		pins(5'h00, 4);
		chk("port B low flag", 8'h00, {7'h00, aSampleFlag});
		aFlagSelect = 1'b0;
	endtask : t_aflag
	task automatic t_reset;
		logic [7:0] d;
		int b;
		nrst = 1'b0;
		repeat (4) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (3) @(negedge ref_clk);
		fspc_host_model_inst.rd(SYNC_START_OFS, d);
		chk("start after reset", 8'h80, d);
		fspc_host_model_inst.rd(SYNC_SRC_OFS, d);
		chk("source after reset", 8'h15, d);
		// Reset alone must re-arm the port B one-shot
		b = loads;
		pins(5'h10, 8);
		chk("reset rearm loads", 8'h01, 8'(loads - b));
	endtask : t_reset
	////////////////////////////////////////////////////////////////////////
	initial begin
		aFlagSelect = 1'b0;
		singleConverterMode = 1'b0;
		pins(5'h00, 4);
		nrst = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_regs;
		t_power;
		t_sources;
		t_rearm;
		t_aflag;
		t_reset;
		final_report;
	end
	// Tests need under 1000 cycles; ten times that is a hang
	initial begin
		#80000;
		mismatches++;
		final_report;
	end
endmodule : fifo_sync_power_config_bench
`default_nettype wire
